// ==== design/mpfe_cfg.svh ====
// offsets, field positions, reset values and counts of the front end
`ifndef MPFE_CFG_SVH
`define MPFE_CFG_SVH
`define MPFE_OFF_PAGE 8'h00
`define MPFE_OFF_PWR0 8'h04
`define MPFE_OFF_PWR2 8'h08
`define MPFE_OFF_CTRL 8'h0C
`define MPFE_OFF_PORT 4'h1
`define MPFE_OFF_MC 8'h20
`define MPFE_OFF_STAT 8'h24
`define MPFE_OFF_PINS 8'h28
`define MPFE_PWR0_RST 8'h01
`define MPFE_P0_SPEED 0
`define MPFE_P0_APD_EN 1
`define MPFE_CT_DATA 0
`define MPFE_CT_LANE 1
`define MPFE_CT_SCAN 2
`define MPFE_PAGE_SWAP 7
`define MPFE_REG_WIN 8'h7F
`define MPFE_APD_LIMIT 8'h0F
`define MPFE_SYNC_W 47
`define MPFE_PINS 27
`endif

// ==== design/mpfe_pkg.sv ====
// types of the front end
package mpfe_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mpfe_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mpfe_wb_rsp_t;
  typedef struct packed {
    logic [7:0] prim_sel;
    logic [3:0] sec_sel;
    logic reg_sel;
    logic mem_en;
    logic prim_wr_ok;
    logic sec_wr_ok;
    logic flash_wr;
  } mpfe_dec_t;
  typedef enum logic [1:0] {
    MPFE_APD_RUN = 2'h1,
    MPFE_APD_DOWN = 2'h2
  } mpfe_apd_t;
  typedef enum logic [1:0] {
    MPFE_PIN_HOST = 2'h0,
    MPFE_PIN_LOGIC = 2'h1,
    MPFE_PIN_ADDR = 2'h2,
    MPFE_PIN_IN = 2'h3
  } mpfe_pin_t;
  typedef struct packed {
    logic [46:0] s1;
    logic [46:0] s2;
    logic lclk_q;
    logic [7:0] page_reg;
    logic [7:0] power0_reg;
    logic [7:0] power2_reg;
    logic [7:0] ctrl_reg;
    logic [3:0][31:0] port_reg;
    logic [15:0] addr_reg;
    logic [15:0] mc_reg;
    logic [23:0] hold_reg;
    logic fetch_prim_reg;
    logic [7:0] apd_cnt_reg;
    mpfe_apd_t apd_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
  } mpfe_state_t;
endpackage

// ==== design/mpfe_front_end.sv ====
// host front end: bus latch, page, decoder, logic array, power, ports
`timescale 1ns/1ps
`default_nettype none
`include "mpfe_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// What this block does
// - chip select low enables, high disables
// - latch strobe on port D bit0 captures address
// - logic array clock pin paces macrocells, power-down
// - primary flash: eight sectors, own selects
// - secondary flash: four sectors, own selects
// - eight-bit page register extends address range
// - page value remaps flash sectors
// - decoder selects are purely combinational
// - sixteen registered macrocells, three combinational outputs
// - twenty-four input macrocells feed the arrays
// - speed bit zero: array sleeps until input change
// - power register two blocks array inputs
// - auto power-down while host bus idle
// - each of 27 pins configurable
// - ports A and B as data port
// - scan signals share port C pins
// - scan port programs device without host
// - host programs one flash from other
// - logic configuration only via scan port
module mpfe_front_end (
  input wire logic mclk,
  input wire logic arst_n,
  input wire mpfe_pkg::mpfe_wb_req_t wb_req,
  output wire mpfe_pkg::mpfe_wb_rsp_t wb_rsp,
  input wire logic [15:0] host_ad,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic host_fetch_n,
  input wire logic scan_force,
  input wire logic [26:0] pin_in,
  output wire logic [26:0] pin_out,
  output wire logic [26:0] pin_oe_n,
  output var mpfe_pkg::mpfe_dec_t dec,
  output wire logic [2:0] lga_comb,
  output wire logic power_down,
  output wire logic cfg_prog_en,
  output wire logic scan_tck,
  output wire logic scan_tms,
  output wire logic scan_tdi,
  input wire logic scan_prog_status,
  input wire logic scan_prog_error,
  input wire logic scan_tdo
);

  mpfe_pkg::mpfe_state_t s;
  mpfe_pkg::mpfe_state_t n;

  logic [26:0] pins;
  logic [15:0] had;
  logic cs_n, ale, lclk, ben_n, wr_n, rd_n, fetch_n;
  logic scan_on, lclk_rise, live, host_act, en, regwin, swap;
  logic [23:0] ib;

  function automatic logic [31:0] bw(input logic [31:0] o,
                                     input logic [31:0] d,
                                     input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // synchronised pins; only s2 is ever read
  assign pins = s.s2[26:0];
  assign had = s.s2[42:27];
  assign wr_n = s.s2[43];
  assign rd_n = s.s2[44];
  assign fetch_n = s.s2[45];
  // chip select on port D bit2
  assign cs_n = pins[26];
  assign ale = pins[24];
  // array clock pin, edge used as enable
  assign lclk = pins[25];
  assign ben_n = pins[23];
  // strap pin opens scan port on a blank part
  assign scan_on = s.ctrl_reg[`MPFE_CT_SCAN] | s.s2[46];
  assign lclk_rise = lclk & ~s.lclk_q;
  // input macrocells from ports A, B, C
  // power register two blocks a group per bit
  assign ib = pins[23:0] & ~{{8{s.power2_reg[2]}}, {8{s.power2_reg[1]}},
                             {8{s.power2_reg[0]}}};
  // asleep unless speed set or inputs moved
  assign live = s.power0_reg[`MPFE_P0_SPEED] | (ib != s.hold_reg);
  assign host_act = ~cs_n | ale;
  assign power_down = (s.apd_reg == mpfe_pkg::MPFE_APD_DOWN);
  // configuration writes only ever open to scan
  assign cfg_prog_en = scan_on;
  // combinational outputs read the held inputs
  assign lga_comb = {^s.hold_reg[23:16], |s.hold_reg[15:8],
                     &s.hold_reg[7:0]};
  assign wb_rsp = '{ack: s.ack_reg, dat: s.rdata_reg};

  //////////////////////////////////////////////////////////////////////////
  // address decoder, no flops in the select path
  always_comb begin
    // selects dead while chip select high or powered down
    en = ~cs_n & ~power_down;
    regwin = (s.addr_reg[15:8] == `MPFE_REG_WIN);
    // page top bit swaps flash halves
    swap = s.page_reg[`MPFE_PAGE_SWAP];
    dec = '0;
    dec.mem_en = en;
    dec.reg_sel = en & regwin;
    if (en & ~regwin & (s.addr_reg[15] ^ swap)) begin
      // 32K primary sector chosen by page bits
      dec.prim_sel = 8'h01 << s.page_reg[2:0];
    end
    if (en & ~regwin & ~(s.addr_reg[15] ^ swap)) begin
      dec.sec_sel = 4'h1 << s.addr_reg[14:13];
    end
    // byte-lane host must qualify the write
    dec.flash_wr = en & ~regwin & ~wr_n &
                   (~s.ctrl_reg[`MPFE_CT_LANE] | ~ben_n);
    // program the flash not being executed from
    dec.prim_wr_ok = ~s.fetch_prim_reg & ~scan_on;
    dec.sec_wr_ok = s.fetch_prim_reg & ~scan_on;
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = s;
    n.s1 = {scan_force, host_fetch_n, host_rd_n, host_wr_n, host_ad, pin_in};
    n.s2 = s.s1;
    n.lclk_q = lclk;
    n.ack_reg = 1'b0;
    if (s.ctrl_reg[`MPFE_CT_DATA]) begin
      n.addr_reg = had;
    end else if (ale) begin
      n.addr_reg = had;
    end
    if (~fetch_n & en) begin
      n.fetch_prim_reg = |dec.prim_sel;
    end
    // hold captures inputs only while awake
    if (live) begin
      n.hold_reg = ib;
    end
    // macrocells step on array clock edges
    if (lclk_rise & live) begin
      n.mc_reg = ib[15:0] ^ ib[23:8];
    end
    // idle bus counts array clocks to power-down
    unique case (s.apd_reg)
      mpfe_pkg::MPFE_APD_RUN: begin
        if (host_act | ~s.power0_reg[`MPFE_P0_APD_EN]) begin
          n.apd_cnt_reg = 8'h00;
        end else if (lclk_rise) begin
          if (s.apd_cnt_reg == `MPFE_APD_LIMIT) begin
            n.apd_reg = mpfe_pkg::MPFE_APD_DOWN;
          end else begin
            n.apd_cnt_reg = s.apd_cnt_reg + 8'h01;
          end
        end
      end
      mpfe_pkg::MPFE_APD_DOWN: begin
        if (host_act) begin
          n.apd_reg = mpfe_pkg::MPFE_APD_RUN;
          n.apd_cnt_reg = 8'h00;
        end
      end
    endcase
    // register slave; ack one cycle, then a dead cycle
    if (wb_req.cyc & wb_req.stb & ~s.ack_reg) begin
      n.ack_reg = 1'b1;
      n.rdata_reg = 32'h0000_0000;
      if (wb_req.adr[7:4] == `MPFE_OFF_PORT && wb_req.adr[1:0] == 2'h0) begin
        n.rdata_reg = s.port_reg[wb_req.adr[3:2]];
        if (wb_req.we) begin
          n.port_reg[wb_req.adr[3:2]] =
            bw(s.port_reg[wb_req.adr[3:2]], wb_req.dat, wb_req.sel);
        end
      end
      unique case (wb_req.adr)
        `MPFE_OFF_PAGE: begin
          n.rdata_reg = {24'h000000, s.page_reg};
          if (wb_req.we & wb_req.sel[0]) begin
            n.page_reg = wb_req.dat[7:0];
          end
        end
        `MPFE_OFF_PWR0: begin
          n.rdata_reg = {24'h000000, s.power0_reg};
          if (wb_req.we & wb_req.sel[0]) begin
            n.power0_reg = wb_req.dat[7:0];
          end
        end
        `MPFE_OFF_PWR2: begin
          n.rdata_reg = {24'h000000, s.power2_reg};
          if (wb_req.we & wb_req.sel[0]) begin
            n.power2_reg = wb_req.dat[7:0];
          end
        end
        `MPFE_OFF_CTRL: begin
          n.rdata_reg = {24'h000000, s.ctrl_reg};
          if (wb_req.we & wb_req.sel[0]) begin
            n.ctrl_reg = wb_req.dat[7:0];
          end
        end
        `MPFE_OFF_MC: begin
          n.rdata_reg = {16'h0000, s.mc_reg};
          // host load wins over an array edge in the same cycle
          if (wb_req.we) begin
            n.mc_reg = 16'(bw({16'h0000, s.mc_reg}, wb_req.dat,
                              wb_req.sel));
          end
        end
        `MPFE_OFF_STAT: begin
          n.rdata_reg = {28'h0000000, power_down, s.fetch_prim_reg,
                         scan_on, ~live};
        end
        `MPFE_OFF_PINS: begin
          n.rdata_reg = {5'h00, pins};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.power0_reg <= `MPFE_PWR0_RST;
      s.apd_reg <= mpfe_pkg::MPFE_APD_RUN;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pins; scan taps are raw synced levels, so tck must stay slow
  // scan inputs from C0, C1, C5
  assign scan_tms = scan_on & pins[16];
  assign scan_tck = scan_on & pins[17];
  assign scan_tdi = scan_on & pins[21];

  for (genvar i = 0; i < `MPFE_PINS; i++) begin : g_pin
    localparam bit SIN = (i == 16) || (i == 17) || (i == 21);
    localparam bit SOUT = (i == 19) || (i == 20) || (i == 22);
    logic [1:0] md;
    logic o, e_n, so;
    assign md = s.port_reg[i / 8][16 + 2 * (i % 8) +: 2];
    assign so = (i == 19) ? scan_prog_status :
                (i == 20) ? scan_prog_error : scan_tdo;
    always_comb begin
      o = s.port_reg[i / 8][i % 8];
      e_n = ~s.port_reg[i / 8][8 + i % 8];
      if (i < 16 && s.ctrl_reg[`MPFE_CT_DATA]) begin
        // data port drives only on host read
        e_n = ~(~cs_n & ~rd_n);
      end else if (md == mpfe_pkg::MPFE_PIN_ADDR) begin
        o = s.addr_reg[i % 16];
        e_n = 1'b0;
      end else if (md == mpfe_pkg::MPFE_PIN_LOGIC) begin
        o = s.mc_reg[i % 16];
        e_n = 1'b0;
      end else if (md == mpfe_pkg::MPFE_PIN_IN) begin
        e_n = 1'b1;
      end
      if (scan_on && SIN) begin
        e_n = 1'b1;
      end
      if (scan_on && SOUT) begin
        o = so;
        e_n = 1'b0;
      end
    end
    assign pin_out[i] = o;
    assign pin_oe_n[i] = e_n;
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  cs_gates_sel_a: assert property (
    cs_n |-> (dec.prim_sel == 8'h00 && dec.sec_sel == 4'h0 && !dec.reg_sel))
    else $error("selects active while chip select high");
  ale_latch_a: assert property (
    ale && !s.ctrl_reg[`MPFE_CT_DATA] |=> s.addr_reg == $past(had))
    else $error("address not captured on strobe");
  lane_qual_a: assert property (
    s.ctrl_reg[`MPFE_CT_LANE] && ben_n |-> !dec.flash_wr)
    else $error("write without byte lane enable");
  prim_onehot_a: assert property (
    $onehot0(dec.prim_sel) && (dec.prim_sel == 8'h00 || dec.mem_en))
    else $error("primary selects not one-hot");
  sec_onehot_a: assert property (
    $onehot0(dec.sec_sel) && !(|dec.prim_sel && |dec.sec_sel))
    else $error("secondary selects bad");
  page_remap_a: assert property (
    en && !regwin && swap && !s.addr_reg[15] |-> dec.prim_sel != 8'h00)
    else $error("page swap did not remap");
  sleep_hold_a: assert property (
    !s.power0_reg[`MPFE_P0_SPEED] && ib == s.hold_reg &&
    !(wb_req.cyc && wb_req.stb && wb_req.adr == `MPFE_OFF_MC)
    |=> $stable(s.mc_reg))
    else $error("array changed while asleep");
  block_in_a: assert property (
    s.power2_reg[0] |-> ib[7:0] == 8'h00)
    else $error("blocked inputs reached array");
  apd_down_a: assert property (
    power_down |-> !dec.mem_en ##0 $past(!host_act))
    else $error("power-down with memories on");
  scan_pin_a: assert property (
    scan_on |-> pin_oe_n[16] && !pin_oe_n[22] && pin_out[22] == scan_tdo)
    else $error("scan pins not routed");
  wb_ack_a: assert property (
    wb_req.cyc && wb_req.stb && !s.ack_reg |=> s.ack_reg ##1 !s.ack_reg)
    else $error("bus ack not one cycle");

endmodule
`default_nettype wire

// ==== verification/mpfe_host_model.sv ====
// microcontroller model driving the front end's host pins
`timescale 1ns/1ps
`default_nettype none
module mpfe_host_model (
  input wire logic mclk,
  output var logic [26:0] pin_in,
  output var logic [15:0] host_ad,
  output var logic host_wr_n,
  output var logic host_rd_n,
  output var logic host_fetch_n
);
  initial begin
    pin_in = 27'h4000000;
    host_ad = 16'h0000;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    host_fetch_n = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////
  // strobe captures address
  // released bus shows the inverse, so a late capture cannot pass
  task latch(input logic [15:0] a);
    @(posedge mclk);
    host_ad <= a;
    pin_in[24] <= 1'b1;
    repeat (4) @(posedge mclk);
    pin_in[24] <= 1'b0;
    host_ad <= ~a;
  endtask
  task chip_sel(input logic on);
    @(posedge mclk);
    pin_in[26] <= ~on;
  endtask
  // one rise of the logic array clock
  task lclk_pulse();
    @(posedge mclk);
    pin_in[25] <= 1'b1;
    repeat (2) @(posedge mclk);
    pin_in[25] <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // host write strobe, active low
  task set_wr(input logic v);
    @(posedge mclk);
    host_wr_n <= v;
  endtask
  // byte lane enable and other pins
  task set_pin(input int i, input logic v);
    @(posedge mclk);
    pin_in[i] <= v;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench of the host front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, arst_n, scan_force, power_down, cfg_prog_en;
  mpfe_pkg::mpfe_wb_req_t wb_req;
  mpfe_pkg::mpfe_wb_rsp_t wb_rsp;
  mpfe_pkg::mpfe_dec_t dec;
  logic [26:0] pin_in, pin_out, pin_oe_n;
  logic [15:0] host_ad, a;
  logic host_wr_n, host_rd_n, host_fetch_n, scan_tck, scan_tms, scan_tdi;
  logic scan_prog_status, scan_prog_error, scan_tdo;
  logic [2:0] lga_comb;
  logic [31:0] rd;
  int fails, n_compared, cycles, page;

  mpfe_host_model host_u (.mclk(mclk), .pin_in(pin_in), .host_ad(host_ad),
    .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
    .host_fetch_n(host_fetch_n));
  mpfe_front_end dut_u (.mclk(mclk), .arst_n(arst_n), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .host_ad(host_ad), .host_wr_n(host_wr_n),
    .host_rd_n(host_rd_n), .host_fetch_n(host_fetch_n),
    .scan_force(scan_force), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .dec(dec), .lga_comb(lga_comb),
    .power_down(power_down), .cfg_prog_en(cfg_prog_en),
    .scan_tck(scan_tck), .scan_tms(scan_tms), .scan_tdi(scan_tdi),
    .scan_prog_status(scan_prog_status),
    .scan_prog_error(scan_prog_error), .scan_tdo(scan_tdo));

  //////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] got, input logic [31:0] ex);
    n_compared++;
    if (got !== ex) begin
      fails++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, ex);
    end
  endtask

  task summarize();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one classic cycle; waits up to 50 cycles for ack, else counts a failure
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hF, dat:d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    q = wb_rsp.dat;
    if (n >= 50) begin
      fails++;
      $display("BAD %0t no ack", $time);
    end
    wb_req <= '0;
  endtask

  // decoder model: window, then paged primary, else secondary
  task dec_chk(input logic [15:0] ad, input logic cs_on);
    logic [7:0] ep;
    logic [3:0] es;
    logic er;
    ep = 8'h00;
    es = 4'h0;
    er = 1'b0;
    if (cs_on) begin
      if (ad[15:8] == 8'h7F) er = 1'b1;
      else if (ad[15] ^ page[7]) ep = 8'h01 << page[2:0];
      else es = 4'h1 << ad[14:13];
    end
    repeat (4) @(posedge mclk);
    chk("primary", {24'h0, dec.prim_sel}, {24'h0, ep});
    chk("secondary", {28'h0, dec.sec_sel}, {28'h0, es});
    chk("register", {31'h0, dec.reg_sel}, {31'h0, er});
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end

  initial begin
    arst_n = 1'b0;
    wb_req = '0;
    scan_force = 1'b0;
    scan_prog_status = 1'b0;
    scan_prog_error = 1'b0;
    scan_tdo = 1'b0;
    page = 0;
    void'($urandom(63633));
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    wb(1'b0, 8'h00, 32'h0, rd);
    chk("page reset", rd, 32'h0);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk("power0 reset", rd, 32'h1);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    host_u.chip_sel(1'b1);
    for (int i = 0; i < 12; i++) begin
      page = (i == 0) ? 255 : $urandom_range(255);
      wb(1'b1, 8'h00, 32'(page), rd);
      wb(1'b0, 8'h00, 32'h0, rd);
      chk("page", rd, 32'(page));
      a = 16'($urandom);
      host_u.latch(a);
      dec_chk(a, 1'b1);
    end
    host_u.latch(16'h7F12);
    dec_chk(16'h7F12, 1'b1);
    host_u.chip_sel(1'b0);
    dec_chk(16'h7F12, 1'b0);
    a = 16'($urandom);
    wb(1'b1, 8'h20, {16'h0, a}, rd);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk("macrocells", rd, {16'h0, a});
    wb(1'b1, 8'h04, 32'h0, rd);
    host_u.lclk_pulse();
    wb(1'b0, 8'h20, 32'h0, rd);
    chk("asleep", rd, {16'h0, a});
    wb(1'b1, 8'h08, 32'h7, rd);
    wb(1'b0, 8'h08, 32'h0, rd);
    chk("power2", rd, 32'h7);
    wb(1'b1, 8'h08, 32'h0, rd);
    wb(1'b1, 8'h04, 32'h3, rd);
    repeat (15) host_u.lclk_pulse();
    chk("awake", {31'h0, power_down}, 32'h0);
    host_u.lclk_pulse();
    repeat (4) @(posedge mclk);
    chk("down", {31'h0, power_down}, 32'h1);
    host_u.chip_sel(1'b1);
    repeat (4) @(posedge mclk);
    chk("woken", {31'h0, power_down}, 32'h0);
    wb(1'b1, 8'h0C, 32'h4, rd);
    host_u.set_pin(17, 1'b1);
    scan_prog_status <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("scan open", {31'h0, cfg_prog_en}, 32'h1);
    chk("scan clock", {31'h0, scan_tck}, 32'h1);
    chk("status out", {30'h0, pin_oe_n[19], pin_out[19]}, 32'h1);
    chk("array comb", {29'h0, lga_comb}, 32'h4);
    wb(1'b1, 8'h0C, 32'h2, rd);
    scan_force <= 1'b1;
    host_u.latch(16'h0100);
    host_u.set_wr(1'b0);
    host_u.set_pin(23, 1'b1);
    repeat (4) @(posedge mclk);
    chk("forced scan", {31'h0, cfg_prog_en}, 32'h1);
    chk("lane off", {31'h0, dec.flash_wr}, 32'h0);
    host_u.set_pin(23, 1'b0);
    repeat (4) @(posedge mclk);
    chk("lane on", {31'h0, dec.flash_wr}, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
